//--- src/atp_mmu.sv
// Notes on behaviour
// - pages are 4 KB, offset kept
// - blocks span 128 KB to 256 MB
// - translation off: physical equals effective
// - fetch and data enables act independently
// - top four address bits pick segment
// - direct-store segment raises access fault
// - segment forms virtual, then 32-bit physical
// - cache miss starts hardware hashed search
// - block keeps at least 17 offset bits
// - block hit overrides parallel page result
// - eight page protection options enforced
// - segment no-execute gates instruction fetch
// - other protection from segment plus record
// - supervisor-only page refuses user access
// - guarded memory never accessed speculatively
// - load/fetch search sets referenced bit
// - store search sets referenced and changed
// - store hit, changed clear: set both copies
// - 128-entry two-way caches, LRU replacement
// - address bits 11:0 pass untranslated
// - protection violation faults, access dropped
`timescale 1ns/1ps
`default_nettype none
module atp_mmu
  import atp_pkg::*;
#(
  parameter int HASH_BITS = 10
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // requesters, index 0 fetch, 1 data
  input wire logic [1:0] req_valid,
  input wire atp_req_t req [2],
  output logic [1:0] req_ready,
  output logic [1:0] resp_valid,
  output atp_resp_t resp [2],
  // memory port for table search
  output logic mem_valid,
  output atp_mem_t mem,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata
);
  // ****************************************
  // register file
  // ****************************************
  logic [31:0] msw; // machine_state_word
  logic [31:0] tbl_base; // page table base
  logic [31:0] seg_reg [16]; // shared segments
  logic [31:0] blk_u [2][N_BLK]; // block map upper
  logic [31:0] blk_l [2][N_BLK]; // block map lower
  logic [5:0] last_cause; // per side, for status
  atp_walk_t wst; // search state
  atp_side_t st [2]; // side states
  // decode
  wire wr_en = psel & penable & pwrite & pready;
  wire hit_msw = paddr[11:2] == MSW_OFS[11:2];
  wire hit_tbl = paddr[11:2] == TBL_OFS[11:2];
  wire hit_stat = paddr[11:2] == STAT_OFS[11:2];
  wire hit_seg = paddr[11:6] == SEG_OFS[11:6];
  wire hit_ib = paddr[11:6] == IBLK_OFS[11:6];
  wire hit_db = paddr[11:6] == DBLK_OFS[11:6];
  wire hit_any = hit_msw | hit_tbl | hit_stat | hit_seg | hit_ib | hit_db;
  wire [2:0] bidx = paddr[5:3]; // block entry
  wire bsid = hit_db; // block map side
  wire [31:0] stat_w = {19'h0, wst, last_cause, st[1], st[0]}; // 13 status bits, zero filled
  logic [31:0] rd_mux;
  // read mux
  always_comb begin
    rd_mux = 32'h0;
    if (hit_msw) rd_mux = msw;
    else if (hit_tbl) rd_mux = tbl_base;
    else if (hit_stat) rd_mux = stat_w;
    else if (hit_seg) rd_mux = seg_reg[paddr[5:2]];
    else if (hit_ib | hit_db) begin
      rd_mux = paddr[2] ? blk_l[bsid][bidx] : blk_u[bsid][bidx];
    end
  end
  // apb answer, zero wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      prdata <= rd_mux;
      pslverr <= psel & ~penable & ~hit_any;
    end
  end
  // register writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      msw <= MSW_RST;
      tbl_base <= TBL_RST;
      seg_reg <= '{default: 32'h0}; // all segments cleared
      blk_u <= '{default: 32'h0}; // both block maps invalid
      blk_l <= '{default: 32'h0};
    end else if (wr_en) begin
      if (hit_msw) msw <= pwdata;
      if (hit_tbl) tbl_base <= pwdata;
      if (hit_seg) seg_reg[paddr[5:2]] <= pwdata;
      if ((hit_ib | hit_db) & paddr[2]) blk_l[bsid][bidx] <= pwdata;
      if ((hit_ib | hit_db) & ~paddr[2]) blk_u[bsid][bidx] <= pwdata;
    end
  end
  // ****************************************
  // helpers
  // ****************************************
  // block match, length mask in bits 12:2
  function automatic logic blk_match(input logic [31:0] u, input logic [31:0] ea, input logic usr);
    return (ea[31:28] == u[31:28]) && ((ea[27:17] & ~u[12:2]) == (u[27:17] & ~u[12:2]))
      && (usr ? u[BU_VP] : u[BU_VS]);
  endfunction : blk_match
  // block physical address, low 17 bits kept
  function automatic logic [31:0] blk_addr(input logic [31:0] u, input logic [31:0] l, input logic [31:0] ea);
    return {l[31:28], (l[27:17] & ~u[12:2]) | (ea[27:17] & u[12:2]), ea[16:0]};
  endfunction : blk_addr
  // ****************************************
  // translation caches
  // ****************************************
  logic tc_v [2][2][64]; // valid per side, way, set
  logic [33:0] tc_tag [2][2][64]; // vsid and page index
  logic [23:0] tc_dat [2][2][64]; // rpn, c, g, pp
  logic tc_lru [2][64]; // way to replace next
  logic [1:0] dec_done; // side decided this cycle
  logic [1:0] dec_miss; // side needs a search
  logic [1:0] t_hit; // any way hit
  logic [1:0] t_way; // hit way
  atp_resp_t dec_r [2];
  atp_req_t cur [2]; // captured requests
  // ****************************************
  // per side lookup and control
  // ****************************************
  for (genvar s = 0; s < 2; s++) begin : g_side
    wire [31:0] ea = cur[s].ea;
    wire xl = msw[s];
    wire usr = msw[MSW_USER];
    wire [31:0] seg = seg_reg[ea[31:28]];
    wire [5:0] set = ea[17:12];
    wire [33:0] tag = {seg[23:0], ea[27:18]};
    wire h0 = tc_v[s][0][set] && tc_tag[s][0][set] == tag;
    wire h1 = tc_v[s][1][set] && tc_tag[s][1][set] == tag;
    wire [23:0] td = h1 ? tc_dat[s][1][set] : tc_dat[s][0][set];
    wire key = usr ? seg[SEG_KP] : seg[SEG_KS];
    assign t_hit[s] = h0 | h1;
    assign t_way[s] = h1;
    logic b_hit, b_g;
    logic [1:0] b_pp;
    logic [31:0] b_pa;
    // block map search, lowest entry wins
    always_comb begin
      b_hit = 1'b0;
      b_g = 1'b0;
      b_pp = 2'b00;
      b_pa = 32'h0;
      for (int k = N_BLK - 1; k >= 0; k--) begin
        if (blk_match(blk_u[s][k], ea, usr)) begin
          b_hit = 1'b1;
          b_g = blk_l[s][k][BL_G];
          b_pp = blk_l[s][k][1:0];
          b_pa = blk_addr(blk_u[s][k], blk_l[s][k], ea);
        end
      end
    end
    logic chk, rd, wr, g;
    // selection in fixed priority
    always_comb begin
      dec_r[s] = '0;
      dec_r[s].pa = ea;
      dec_miss[s] = 1'b0;
      chk = 1'b0;
      rd = 1'b0;
      wr = 1'b0;
      g = 1'b0;
      if (!xl) begin
        // real mode
      end else if (b_hit) begin
        dec_r[s].pa = b_pa;
        chk = 1'b1;
        rd = b_pp != 2'b00;
        wr = b_pp == 2'b10;
        g = b_g;
      end else if (seg[SEG_DS]) begin
        dec_r[s].cause = C_DSEG;
      end else if (s == 0 && seg[SEG_NX]) begin
        dec_r[s].cause = C_NOEX;
      end else if (!t_hit[s] || (cur[s].store && !td[3])) begin
        dec_miss[s] = 1'b1;
      end else begin
        dec_r[s].pa = {td[23:4], ea[11:0]};
        chk = 1'b1;
        rd = !(key && td[1:0] == 2'b00);
        wr = key ? td[1:0] == 2'b10 : td[1:0] != 2'b11;
        g = td[2];
      end
      // protection on the chosen result
      if (chk) begin
        if (s == 0 && g) dec_r[s].cause = C_NOEX;
        else if (!(cur[s].store ? wr : rd)) dec_r[s].cause = C_PROT;
        else if (g && cur[s].spec) dec_r[s].refused = 1'b1;
      end
      dec_r[s].fault = dec_r[s].cause != C_NONE;
      dec_r[s].vec = dec_r[s].fault ? (s == 0 ? FETCH_VEC : DATA_VEC) : 20'h0;
      if (dec_r[s].fault) dec_r[s].pa = 32'h0;
    end
    assign dec_done[s] = st[s] == S_EVAL && !dec_miss[s];
  end
  // ****************************************
  // side state machines
  // ****************************************
  logic wk_side; // side being searched
  logic wk_end; // search finished
  logic wk_pf; // no record found
  atp_resp_t pf_r [2];
  for (genvar s = 0; s < 2; s++) begin : g_ctl
    // page fault answer, no address handed out
    assign pf_r[s] = '{pa: 32'h0, fault: 1'b1, refused: 1'b0, cause: C_PAGE,
      vec: s == 0 ? FETCH_VEC : DATA_VEC};
    wire my_end = wk_end && wk_side == s;
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        st[s] <= S_IDLE;
        cur[s] <= '0;
        req_ready[s] <= 1'b1;
        resp_valid[s] <= 1'b0;
        resp[s] <= '0;
        last_cause[3*s+:3] <= 3'b000;
      end else begin
        resp_valid[s] <= 1'b0;
        unique case (st[s])
          S_IDLE: if (req_valid[s]) begin
            cur[s] <= req[s];
            req_ready[s] <= 1'b0;
            st[s] <= S_EVAL;
          end
          S_EVAL: if (dec_miss[s]) begin
            st[s] <= S_WALK;
          end else begin
            resp_valid[s] <= 1'b1;
            resp[s] <= dec_r[s];
            last_cause[3*s+:3] <= dec_r[s].cause;
            req_ready[s] <= 1'b1;
            st[s] <= S_IDLE;
          end
          S_WALK: if (my_end && wk_pf) begin
            resp_valid[s] <= 1'b1;
            resp[s] <= pf_r[s];
            last_cause[3*s+:3] <= C_PAGE;
            req_ready[s] <= 1'b1;
            st[s] <= S_IDLE;
          end else if (my_end) begin
            st[s] <= S_EVAL;
          end
          default: st[s] <= S_IDLE;
        endcase
      end
    end
  end
  // ****************************************
  // hardware table search
  // ****************************************
  logic [2:0] wk_k; // record within group
  logic [31:0] w1; // second word of match
  wire [1:0] wants = {st[1] == S_WALK, st[0] == S_WALK};
  wire [31:0] wea = cur[wk_side].ea;
  wire [23:0] wvsid = seg_reg[wea[31:28]][23:0];
  wire [18:0] hsh = wvsid[18:0] ^ {3'h0, wea[27:12]};
  wire [HASH_BITS-1:0] hmask = '1;
  wire [31:0] grp = {tbl_base[31:6] & ~{{(26 - HASH_BITS){1'b0}}, hmask},
    6'h0} | {{(26 - HASH_BITS){1'b0}}, hsh[HASH_BITS-1:0], 6'h0};
  wire [31:0] rec = {grp[31:6], wk_k, 3'h0};
  wire w0_ok = mem_rdata[REC_V] && !mem_rdata[REC_H]
    && mem_rdata[30:7] == wvsid && mem_rdata[5:0] == wea[27:22];
  wire wst_st = cur[wk_side].store;
  wire upd = wst_st ? !(mem_rdata[REC_R] && mem_rdata[REC_C]) : !mem_rdata[REC_R];
  wire [31:0] w1_new = w1 | (32'h1 << REC_R) | (wst_st ? 32'h1 << REC_C : 32'h0);
  wire [5:0] wset = wea[17:12];
  wire fway = t_hit[wk_side] ? t_way[wk_side] : tc_lru[wk_side][wset];
  // search sequence
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wst <= W_IDLE;
      wk_side <= 1'b0;
      wk_k <= 3'h0;
      w1 <= 32'h0;
      wk_end <= 1'b0;
      wk_pf <= 1'b0;
      mem_valid <= 1'b0;
      mem <= '0;
    end else begin
      wk_end <= 1'b0;
      unique case (wst)
        W_IDLE: if (|wants && !wk_end) begin
          wk_side <= !wants[0];
          wk_k <= 3'h0;
          wst <= W_RD0;
        end
        W_RD0: if (!mem_valid) begin
          mem_valid <= 1'b1;
          mem <= '{addr: rec, we: 1'b0, wdata: 32'h0};
        end else if (mem_ack) begin
          mem_valid <= 1'b0;
          if (w0_ok) wst <= W_RD1;
          else if (wk_k == 3'(PTEG_N - 1)) begin
            wk_end <= 1'b1;
            wk_pf <= 1'b1;
            wst <= W_IDLE;
          end else wk_k <= wk_k + 3'h1;
        end
        W_RD1: if (!mem_valid) begin
          mem_valid <= 1'b1;
          mem <= '{addr: rec | 32'h4, we: 1'b0, wdata: 32'h0};
        end else if (mem_ack) begin
          mem_valid <= 1'b0;
          w1 <= mem_rdata;
          wst <= upd ? W_UPD : W_FILL;
        end
        W_UPD: if (!mem_valid) begin
          mem_valid <= 1'b1;
          mem <= '{addr: rec | 32'h4, we: 1'b1, wdata: w1_new};
        end else if (mem_ack) begin
          mem_valid <= 1'b0;
          wst <= W_FILL;
        end
        W_FILL: begin
          wk_end <= 1'b1;
          wk_pf <= 1'b0;
          wst <= W_IDLE;
        end
        default: wst <= W_IDLE;
      endcase
    end
  end
  // cache fill and lru upkeep
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tc_v <= '{default: 1'b0}; // every entry invalid
      tc_lru <= '{default: 1'b0};
    end else begin
      for (int s = 0; s < 2; s++) begin
        if (dec_done[s] && t_hit[s] && msw[s]) begin
          tc_lru[s][cur[s].ea[17:12]] <= !t_way[s];
        end
      end
      if (wst == W_FILL) begin
        tc_v[wk_side][fway][wset] <= 1'b1;
        tc_tag[wk_side][fway][wset] <= {wvsid, wea[27:18]};
        tc_dat[wk_side][fway][wset] <= {w1_new[31:12], w1[REC_C] | wst_st,
          w1[REC_G], w1[1:0]};
        tc_lru[wk_side][wset] <= !fway;
      end
    end
  end
  // ****************************************
  // checks
  // ****************************************
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_real_pa: assert property (st[1] == S_EVAL && !msw[MSW_DXL] |=> resp_valid[1] && resp[1].pa == cur[1].ea)
    else $error("real mode address changed");
  a_page_offset: assert property (resp_valid[0] && !resp[0].fault |-> resp[0].pa[11:0] == cur[0].ea[11:0])
    else $error("page offset altered");
  a_block_offset: assert property (dec_done[1] && g_side[1].b_hit && msw[1] && !dec_r[1].fault
    |=> resp[1].pa[16:0] == cur[1].ea[16:0])
    else $error("block offset altered");
  a_dseg_fault: assert property (dec_done[1] && msw[1] && !g_side[1].b_hit && g_side[1].seg[SEG_DS]
    |=> resp_valid[1] && resp[1].vec == DATA_VEC)
    else $error("direct-store access not faulted");
  a_noexec_fetch: assert property (st[0] == S_EVAL && msw[0] && !g_side[0].b_hit && !g_side[0].seg[SEG_DS]
    && g_side[0].seg[SEG_NX] |=> resp_valid[0] && resp[0].fault)
    else $error("no-execute fetch allowed");
  a_spec_guard: assert property (resp_valid[1] && resp[1].refused |-> cur[1].spec && !resp[1].fault)
    else $error("guarded refusal without cause");
  a_store_rc: assert property (mem_valid && mem.we |-> mem.wdata[REC_R] && (mem.wdata[REC_C] || !wst_st))
    else $error("history bits not set");
  a_search_start: assert property (st[1] == S_EVAL && dec_miss[1] |=> st[1] == S_WALK ##[1:3] wst != W_IDLE)
    else $error("miss did not start search");
  a_fill_hit: assert property (wk_end && !wk_pf |=> st[wk_side] == S_EVAL ##0 !dec_miss[wk_side])
    else $error("fill did not hit");
  c_block_hit: cover property (resp_valid[1] && !resp[1].fault && msw[1] && g_side[1].b_hit);
  c_page_fault: cover property (resp_valid[0] && resp[0].cause == C_PAGE);
  c_rc_write: cover property (mem_valid && mem.we && mem_ack);
  c_prot_fault: cover property (resp_valid[1] && resp[1].cause == C_PROT);
endmodule : atp_mmu
`default_nettype wire

//--- src/atp_pkg.sv
// ****************************************
// translation unit constants and types
// ****************************************
package atp_pkg;
  // register byte offsets
  localparam logic [11:0] MSW_OFS = 12'h000;
  localparam logic [11:0] TBL_OFS = 12'h004;
  localparam logic [11:0] STAT_OFS = 12'h008;
  localparam logic [11:0] SEG_OFS = 12'h040;
  localparam logic [11:0] IBLK_OFS = 12'h080;
  localparam logic [11:0] DBLK_OFS = 12'h0c0;
  // reset values
  localparam logic [31:0] MSW_RST = 32'h0000_0000;
  localparam logic [31:0] TBL_RST = 32'h0000_0000;
  // machine_state_word bits
  localparam int MSW_IXL = 0;
  localparam int MSW_DXL = 1;
  localparam int MSW_USER = 2;
  // segment register fields
  localparam int SEG_DS = 31;
  localparam int SEG_KS = 30;
  localparam int SEG_KP = 29;
  localparam int SEG_NX = 28;
  // block map fields
  localparam int BU_VS = 1;
  localparam int BU_VP = 0;
  localparam int BL_G = 3;
  localparam int N_BLK = 8;
  // page_table_record fields
  localparam int REC_V = 31;
  localparam int REC_H = 6;
  localparam int REC_R = 8;
  localparam int REC_C = 7;
  localparam int REC_G = 3;
  localparam int PTEG_N = 8;
  // fault vectors
  localparam logic [19:0] DATA_VEC = 20'h00300;
  localparam logic [19:0] FETCH_VEC = 20'h00400;
  // fault causes
  typedef enum logic [2:0] {
    C_NONE = 3'b000, C_PAGE = 3'b001, C_PROT = 3'b010,
    C_NOEX = 3'b011, C_DSEG = 3'b100
  } atp_cause_t;
  // requester side states
  typedef enum logic [1:0] {
    S_IDLE = 2'b00, S_EVAL = 2'b01, S_WALK = 2'b10
  } atp_side_t;
  // table search states
  typedef enum logic [2:0] {
    W_IDLE = 3'b000, W_RD0 = 3'b001, W_RD1 = 3'b010,
    W_UPD = 3'b011, W_FILL = 3'b100
  } atp_walk_t;
  // request and answer carriers
  typedef struct packed {
    logic [31:0] ea;
    logic store;
    logic spec;
  } atp_req_t;
  typedef struct packed {
    logic [31:0] pa;
    logic fault;
    logic refused;
    atp_cause_t cause;
    logic [19:0] vec;
  } atp_resp_t;
  typedef struct packed {
    logic [31:0] addr;
    logic we;
    logic [31:0] wdata;
  } atp_mem_t;
endpackage : atp_pkg

//--- verif/address_translation_protection_test.sv
`timescale 1ns/1ps
`default_nettype none
module address_translation_protection_test
  import atp_pkg::*;
;
  // ****************************************
  // signals
  // ****************************************
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [1:0] req_valid, req_ready, resp_valid;
  atp_req_t req_s [2];
  atp_resp_t resp_s [2];
  atp_resp_t got; // last answer taken
  logic mem_valid, mem_ack, rerr;
  atp_mem_t mem;
  logic [31:0] mem_rdata;
  logic [3:0] lat; // memory answer delay
  int err_total, n_compared, cycles;
  // ****************************************
  // design and memory model
  // ****************************************
  atp_mmu atp_mmu_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .req_valid(req_valid), .req(req_s), .req_ready(req_ready), .resp_valid(resp_valid), .resp(resp_s),
    .mem_valid(mem_valid), .mem(mem), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  atp_mem_model atp_mem_model_i (.pclk(pclk), .presetn(presetn), .mem_valid(mem_valid), .mem(mem),
    .lat(lat), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  // ****************************************
  // clock, timeout, shared tasks
  // ****************************************
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // cut a hang short
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      final_report();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL %0t got %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // one apb transfer, held until pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  // one translation request on side s, waits for its answer
  task automatic rq(input int s, input logic [31:0] ea, input logic st, input logic sp);
    req_s[s] <= '{ea: ea, store: st, spec: sp};
    req_valid[s] <= 1'b1;
    do @(posedge pclk); while (req_ready[s] !== 1'b1);
    req_valid[s] <= 1'b0;
    do @(posedge pclk); while (resp_valid[s] !== 1'b1);
    got = resp_s[s];
  endtask : rq
  task automatic ck(input logic [31:0] pa, input logic f, input atp_cause_t c, input logic [19:0] v);
    chk(got.pa, pa);
    chk({31'h0, got.fault}, {31'h0, f});
    chk({29'h0, got.cause}, {29'h0, c});
    chk({12'h0, got.vec}, {12'h0, v});
  endtask : ck
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report
  // ****************************************
  // scenarios
  // ****************************************
  // msw reset value, segment readback, unmapped address
  task automatic t_regs;
    apb(1'b0, MSW_OFS, 32'h0);
    chk(rdat, MSW_RST);
    apb(1'b1, SEG_OFS + 12'h008, 32'h8000_0000);
    apb(1'b0, SEG_OFS + 12'h008, 32'h0);
    chk(rdat, 32'h8000_0000);
    apb(1'b0, 12'hffc, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    chk(rdat, 32'h0);
  endtask : t_regs
  // real mode per side, direct-store segment faults
  task automatic t_real;
    rq(1, 32'h1234_5678, 1'b0, 1'b0);
    ck(32'h1234_5678, 1'b0, C_NONE, 20'h0);
    apb(1'b1, MSW_OFS, 32'h1);
    rq(1, 32'h2100_0008, 1'b0, 1'b0);
    ck(32'h2100_0008, 1'b0, C_NONE, 20'h0);
    rq(0, 32'h2100_0008, 1'b0, 1'b0);
    ck(32'h0, 1'b1, C_DSEG, FETCH_VEC);
    apb(1'b1, MSW_OFS, 32'h2);
    rq(1, 32'h2100_0000, 1'b1, 1'b0);
    ck(32'h0, 1'b1, C_DSEG, DATA_VEC);
    rq(0, 32'h2100_0004, 1'b0, 1'b0);
    ck(32'h2100_0004, 1'b0, C_NONE, 20'h0);
  endtask : t_real
  // block hit over a faulting segment, size range, guarded speculation
  task automatic t_block;
    apb(1'b1, DBLK_OFS, 32'h2000_0003);
    apb(1'b1, DBLK_OFS + 12'h004, 32'h4000_0002);
    rq(1, 32'h2001_2345, 1'b0, 1'b0);
    ck(32'h4001_2345, 1'b0, C_NONE, 20'h0);
    apb(1'b1, DBLK_OFS, 32'h2000_1fff);
    rq(1, 32'h2abc_def0, 1'b1, 1'b0);
    ck(32'h4abc_def0, 1'b0, C_NONE, 20'h0);
    apb(1'b1, DBLK_OFS + 12'h004, 32'h4000_000a);
    rq(1, 32'h2abc_def0, 1'b0, 1'b1);
    chk({31'h0, got.refused}, 32'h1);
    apb(1'b1, MSW_OFS, 32'h3);
    rq(0, 32'h2abc_def0, 1'b0, 1'b0);
    ck(32'h0, 1'b1, C_DSEG, FETCH_VEC);
  endtask : t_block
  // page search, history bits, protection, no-execute
  task automatic t_page;
    apb(1'b1, TBL_OFS, 32'h0010_0000);
    apb(1'b1, SEG_OFS + 12'h004, 32'h2000_0000);
    atp_mem_model_i.put(32'h0010_0000, 32'h8000_0000);
    atp_mem_model_i.put(32'h0010_0004, 32'h5555_5002);
    atp_mem_model_i.put(32'h0010_0040, 32'h8000_0000);
    atp_mem_model_i.put(32'h0010_0044, 32'h6666_6000);
    rq(1, 32'h1000_0abc, 1'b0, 1'b0);
    ck(32'h5555_5abc, 1'b0, C_NONE, 20'h0);
    chk(atp_mem_model_i.peek(32'h0010_0004), 32'h5555_5102);
    lat <= 4'h3;
    rq(1, 32'h1000_0ffc, 1'b1, 1'b0);
    ck(32'h5555_5ffc, 1'b0, C_NONE, 20'h0);
    chk(atp_mem_model_i.peek(32'h0010_0004), 32'h5555_5182);
    rq(1, 32'h1000_1010, 1'b1, 1'b0);
    ck(32'h6666_6010, 1'b0, C_NONE, 20'h0);
    chk(atp_mem_model_i.peek(32'h0010_0044), 32'h6666_6180);
    apb(1'b1, MSW_OFS, 32'h7);
    rq(1, 32'h1000_1010, 1'b0, 1'b0);
    ck(32'h0, 1'b1, C_PROT, DATA_VEC);
    apb(1'b1, SEG_OFS + 12'h004, 32'h3000_0000);
    rq(0, 32'h1000_0abc, 1'b0, 1'b0);
    ck(32'h0, 1'b1, C_NOEX, FETCH_VEC);
    // fetch through an empty hash group: eight records miss
    rq(0, 32'h3000_2000, 1'b0, 1'b0);
    ck(32'h0, 1'b1, C_PAGE, FETCH_VEC);
    // status keeps the last cause of each side
    apb(1'b0, STAT_OFS, 32'h0);
    chk(rdat, {19'h0, W_IDLE, C_PROT, C_PAGE, S_IDLE, S_IDLE});
  endtask : t_page
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    req_valid = 2'b00;
    req_s[0] = '0;
    req_s[1] = '0;
    lat = 4'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_real();
    t_block();
    t_page();
    final_report();
  end
endmodule : address_translation_protection_test
`default_nettype wire

//--- verif/atp_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// memory subsystem seen by the table search
// ****************************************
module atp_mem_model
  import atp_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // request from the unit
  input wire logic mem_valid,
  input wire atp_mem_t mem,
  // idle cycles before each ack
  input wire logic [3:0] lat,
  // answer
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  logic [31:0] words [logic [31:0]]; // sparse word store
  logic [3:0] waited; // cycles spent on this request
  // preload a word
  task automatic put(input logic [31:0] a, input logic [31:0] d);
    words[a] = d;
  endtask : put
  // inspect a word, unwritten ones read as zero
  function automatic logic [31:0] peek(input logic [31:0] a);
    return words.exists(a) ? words[a] : 32'h0000_0000;
  endfunction : peek
  // ack after lat idle cycles; data line scrambled outside the ack cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack <= 1'b0;
      mem_rdata <= 32'h5a5a_a5a5;
      waited <= 4'h0;
    end else if (mem_ack) begin
      // a write lands at the completing edge only
      if (mem_valid && mem.we) words[mem.addr] = mem.wdata;
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      waited <= 4'h0;
    end else if (mem_valid && waited == lat) begin
      mem_ack <= 1'b1;
      mem_rdata <= peek(mem.addr);
    end else begin
      if (mem_valid) waited <= waited + 4'h1;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule : atp_mem_model
`default_nettype wire
